/* File: hw/sram_boundary_scan_tap.sv */
// serial boundary scan test port of the sram, sampled on the core clock
`timescale 1ns/10ps
module sram_boundary_scan_tap
    import scan_tap_pkg::*;
#(
    parameter logic [ID_WIDTH-1:0] ID_CODE = ID_CODE_DEFAULT, // arbitrary value
    parameter int BSR_LEN = BSR_WIDTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tck_pin,
    input wire logic tms_pin,
    input wire logic tms_pin_connected,
    input wire logic tdi_pin,
    input wire logic tdi_pin_connected,
    input wire logic [BSR_LEN-1:0] pin_states,
    output logic tdo_out,
    output logic tdo_oe,
    output logic mem_out_float,
    output logic tap_in_reset
);
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tms_raw;
    logic tdi_raw;
    logic tck_prev_r;
    logic tck_rise;
    logic tck_fall;
    tap_state_t state;

    logic [IR_WIDTH-1:0] ir_shift_r, ir_shift_nxt;
    logic [IR_WIDTH-1:0] ir_active_r, ir_active_nxt;
    logic bypass_r, bypass_nxt;
    logic [ID_WIDTH-1:0] id_r, id_nxt;
    logic [BSR_LEN-1:0] bsr_r, bsr_nxt;
    logic tdo_r, tdo_nxt;
    logic tdo_oe_r, tdo_oe_nxt;
    logic [2:0] tms_high_cnt_r, tms_high_cnt_nxt;
    logic sel_id;
    logic sel_bsr;
    logic sel_bypass;
    logic lsb_bit;

    // unconnected pins read high
    assign tms_raw = tms_pin_connected ? tms_pin : 1'b1;
    assign tdi_raw = tdi_pin_connected ? tdi_pin : 1'b1;

    pin_sync3 u_sync_tck (
        .core_clk(core_clk),
        .reset(reset),
        .pin(tck_pin),
        .reset_level(1'b0),
        .level(tck_s)
    );
    pin_sync3 u_sync_tms (
        .core_clk(core_clk),
        .reset(reset),
        .pin(tms_raw),
        .reset_level(1'b1),
        .level(tms_s)
    );
    pin_sync3 u_sync_tdi (
        .core_clk(core_clk),
        .reset(reset),
        .pin(tdi_raw),
        .reset_level(1'b1),
        .level(tdi_s)
    );

    // a test clock held low never produces a rise, so nothing moves
    assign tck_rise = tck_s & ~tck_prev_r;
    assign tck_fall = ~tck_s & tck_prev_r;

    tap_fsm u_fsm (
        .core_clk(core_clk),
        .reset(reset),
        .tck_rise(tck_rise),
        .tms(tms_s),
        .state(state)
    );

    // data register select from the active instruction
    always_comb begin
        sel_id = 1'b0;
        sel_bsr = 1'b0;
        sel_bypass = 1'b0;
        unique case (ir_active_r)
            INSTR_IDCODE: sel_id = 1'b1;
            INSTR_ALL_ZERO, INSTR_SAMPLE_Z, INSTR_SAMPLE: sel_bsr = 1'b1;
            default: sel_bypass = 1'b1;
        endcase
    end

    // five high samples counted independently of the state walk
    always_comb begin
        tms_high_cnt_nxt = tms_high_cnt_r;
        if (tck_rise) begin
            if (!tms_s) begin
                tms_high_cnt_nxt = 3'h0;
            end else if (tms_high_cnt_r != 3'(RESET_TMS_EDGES)) begin
                tms_high_cnt_nxt = tms_high_cnt_r + 3'h1;
            end
        end
    end

    // shift, capture and update on the test clock rise
    always_comb begin
        ir_shift_nxt = ir_shift_r;
        ir_active_nxt = ir_active_r;
        bypass_nxt = bypass_r;
        id_nxt = id_r;
        bsr_nxt = bsr_r;
        // the reset state loads the identification instruction at the end of its first cycle
        if (state == TEST_LOGIC_RESET) begin
            ir_active_nxt = IR_RESET_VALUE;
            ir_shift_nxt = IR_RESET_VALUE;
        end
        if (tck_rise) begin
            unique case (state)
                TEST_LOGIC_RESET: begin
                    ir_active_nxt = IR_RESET_VALUE;
                    ir_shift_nxt = IR_RESET_VALUE;
                end
                CAPTURE_IR: begin
                    ir_shift_nxt = {ir_shift_r[IR_WIDTH-1:2], IR_CAPTURE_PATTERN};
                end
                SHIFT_IR: begin
                    ir_shift_nxt = {tdi_s, ir_shift_r[IR_WIDTH-1:1]};
                end
                UPDATE_IR: begin
                    ir_active_nxt = ir_shift_r;
                end
                CAPTURE_DR: begin
                    if (sel_id) begin
                        id_nxt = ID_CODE;
                    end
                    if (sel_bsr) begin
                        bsr_nxt = pin_states;
                    end
                    if (sel_bypass) begin
                        bypass_nxt = 1'b0;
                    end
                end
                SHIFT_DR: begin
                    if (sel_id) begin
                        id_nxt = {tdi_s, id_r[ID_WIDTH-1:1]};
                    end
                    if (sel_bsr) begin
                        bsr_nxt = {tdi_s, bsr_r[BSR_LEN-1:1]};
                    end
                    if (sel_bypass) begin
                        bypass_nxt = tdi_s;
                    end
                end
                default: begin
                end
            endcase
            // five high rises force the reset instruction into both instruction registers even from a stuck walk
            if (tms_s && tms_high_cnt_r == 3'(RESET_TMS_EDGES - 1)) begin
                ir_active_nxt = IR_RESET_VALUE;
                ir_shift_nxt = IR_RESET_VALUE;
            end
        end
    end

    // serial output driven on the test clock fall
    always_comb begin
        lsb_bit = bypass_r;
        if (state == SHIFT_IR) begin
            lsb_bit = ir_shift_r[0];
        end else if (sel_id) begin
            lsb_bit = id_r[0];
        end else if (sel_bsr) begin
            lsb_bit = bsr_r[0];
        end
        tdo_nxt = tdo_r;
        tdo_oe_nxt = tdo_oe_r;
        if (tck_fall) begin
            tdo_nxt = lsb_bit;
            tdo_oe_nxt = (state == SHIFT_IR) || (state == SHIFT_DR);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tck_prev_r <= 1'b0;
            ir_shift_r <= IR_RESET_VALUE;
            ir_active_r <= IR_RESET_VALUE;
            bypass_r <= 1'b0;
            id_r <= '0;
            bsr_r <= '0;
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
            tms_high_cnt_r <= 3'h0;
        end else begin
            tck_prev_r <= tck_s;
            ir_shift_r <= ir_shift_nxt;
            ir_active_r <= ir_active_nxt;
            bypass_r <= bypass_nxt;
            id_r <= id_nxt;
            bsr_r <= bsr_nxt;
            tdo_r <= tdo_nxt;
            tdo_oe_r <= tdo_oe_nxt;
            tms_high_cnt_r <= tms_high_cnt_nxt;
        end
    end

    assign tdo_out = tdo_r;
    assign tdo_oe = tdo_oe_r;
    // only the output float request reaches the memory; the core runs on regardless
    assign mem_out_float = (ir_active_r == INSTR_ALL_ZERO) ||
                           (ir_active_r == INSTR_SAMPLE_Z);
    assign tap_in_reset = (state == TEST_LOGIC_RESET);
endmodule // sram_boundary_scan_tap

/* File: hw/scan_tap_pkg.sv */
// shared constants and types for the sram boundary scan port
package scan_tap_pkg;
    localparam int IR_WIDTH = 3;
    localparam int ID_WIDTH = 32;
    localparam int BSR_WIDTH = 71;
    localparam int RESET_TMS_EDGES = 5;
    localparam logic [2:0] INSTR_ALL_ZERO = 3'h0;
    localparam logic [2:0] INSTR_IDCODE = 3'h1;
    localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INSTR_SAMPLE = 3'h4;
    localparam logic [2:0] INSTR_BYPASS = 3'h7;
    localparam logic [2:0] IR_RESET_VALUE = INSTR_IDCODE;
    localparam logic [1:0] IR_CAPTURE_PATTERN = 2'h1;
    localparam logic [31:0] ID_CODE_DEFAULT = 32'h00000001;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET = 4'h0,
        RUN_TEST_IDLE = 4'h1,
        SELECT_DR_SCAN = 4'h2,
        CAPTURE_DR = 4'h3,
        SHIFT_DR = 4'h4,
        EXIT1_DR = 4'h5,
        PAUSE_DR = 4'h6,
        EXIT2_DR = 4'h7,
        UPDATE_DR = 4'h8,
        SELECT_IR_SCAN = 4'h9,
        CAPTURE_IR = 4'ha,
        SHIFT_IR = 4'hb,
        EXIT1_IR = 4'hc,
        PAUSE_IR = 4'hd,
        EXIT2_IR = 4'he,
        UPDATE_IR = 4'hf
    } tap_state_t;
endpackage

/* File: hw/pin_sync3.sv */
// three-stage pin synchroniser, output changes when stages two and three agree
`timescale 1ns/10ps
module pin_sync3 (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic pin,
    input wire logic reset_level,
    output logic level
);
    logic [2:0] stage_r;
    logic [2:0] stage_nxt;
    logic level_r;
    logic level_nxt;

    always_comb begin
        stage_nxt = {stage_r[1:0], pin};
        level_nxt = level_r;
        if (stage_r[1] == stage_r[2]) begin
            level_nxt = stage_r[2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stage_r <= {3{reset_level}};
            level_r <= reset_level;
        end else begin
            stage_r <= stage_nxt;
            level_r <= level_nxt;
        end
    end

    assign level = level_r;
endmodule // pin_sync3

/* File: hw/tap_fsm.sv */
// sixteen-state tap controller stepped on each test clock rise
`timescale 1ns/10ps
module tap_fsm
    import scan_tap_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tck_rise,
    input wire logic tms,
    output tap_state_t state
);
    tap_state_t state_r;
    tap_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        if (tck_rise) begin
            unique case (state_r)
                TEST_LOGIC_RESET: state_nxt = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
                RUN_TEST_IDLE: state_nxt = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
                SELECT_DR_SCAN: state_nxt = tms ? SELECT_IR_SCAN : CAPTURE_DR;
                CAPTURE_DR: state_nxt = tms ? EXIT1_DR : SHIFT_DR;
                SHIFT_DR: state_nxt = tms ? EXIT1_DR : SHIFT_DR;
                EXIT1_DR: state_nxt = tms ? UPDATE_DR : PAUSE_DR;
                PAUSE_DR: state_nxt = tms ? EXIT2_DR : PAUSE_DR;
                EXIT2_DR: state_nxt = tms ? UPDATE_DR : SHIFT_DR;
                UPDATE_DR: state_nxt = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
                SELECT_IR_SCAN: state_nxt = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
                CAPTURE_IR: state_nxt = tms ? EXIT1_IR : SHIFT_IR;
                SHIFT_IR: state_nxt = tms ? EXIT1_IR : SHIFT_IR;
                EXIT1_IR: state_nxt = tms ? UPDATE_IR : PAUSE_IR;
                PAUSE_IR: state_nxt = tms ? EXIT2_IR : PAUSE_IR;
                EXIT2_IR: state_nxt = tms ? UPDATE_IR : SHIFT_IR;
                UPDATE_IR: state_nxt = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= TEST_LOGIC_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign state = state_r;
endmodule // tap_fsm

/* File: tb/scan_tap_host.sv */
// scan controller model that drives the test port pins
`timescale 1ns/10ps
module scan_tap_host (
    output logic tck_pin,
    output logic tms_pin,
    output logic tdi_pin,
    input wire logic tdo_out,
    input wire logic tdo_oe
);
    initial begin
        tck_pin = 1'b0;
        tms_pin = 1'b1;
        tdi_pin = 1'b1;
    end
    // one test clock period; tdo is taken 80 ns after the rise, floating reads as z
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_pin = tms;
        tdi_pin = tdi;
        #160;
        tck_pin = 1'b1;
        #80;
        tdo = tdo_oe ? tdo_out : 1'bz;
        tdi_pin = ~tdi;
        #80;
        tck_pin = 1'b0;
    endtask
    // from run-test-idle through one ir or dr scan and back to idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b1, b);
        if (ir) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
endmodule // scan_tap_host

/* File: tb/sram_boundary_scan_tap_asserts.sv */
// concurrent checks on the scan port pins
`timescale 1ns/10ps
module sram_boundary_scan_tap_asserts (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tck_pin,
    input wire logic tms_pin,
    input wire logic tms_pin_connected,
    input wire logic tdo_out,
    input wire logic tdo_oe,
    input wire logic mem_out_float,
    input wire logic tap_in_reset
);
    logic tck_q_r, tck_q_nxt;
    logic [2:0] high_cnt_r, high_cnt_nxt;
    logic [3:0] rise_age_r, rise_age_nxt;
    logic [3:0] fall_age_r, fall_age_nxt;
    // counts test clock rises seen with mode select high, and cycles since each pin edge
    always_comb begin
        tck_q_nxt = tck_pin;
        high_cnt_nxt = high_cnt_r;
        rise_age_nxt = (rise_age_r == 4'hf) ? rise_age_r : rise_age_r + 4'h1;
        fall_age_nxt = (fall_age_r == 4'hf) ? fall_age_r : fall_age_r + 4'h1;
        if (reset) begin
            tck_q_nxt = 1'b0;
            high_cnt_nxt = 3'h0;
            rise_age_nxt = 4'hf;
            fall_age_nxt = 4'hf;
        end else if (tck_pin && !tck_q_r) begin
            rise_age_nxt = 4'h0;
            if (tms_pin || !tms_pin_connected) begin
                high_cnt_nxt = (high_cnt_r == 3'h5) ? 3'h5 : high_cnt_r + 3'h1;
            end else begin
                high_cnt_nxt = 3'h0;
            end
        end else if (!tck_pin && tck_q_r) begin
            fall_age_nxt = 4'h0;
        end
    end
    always_ff @(posedge core_clk) begin
        tck_q_r <= tck_q_nxt;
        high_cnt_r <= high_cnt_nxt;
        rise_age_r <= rise_age_nxt;
        fall_age_r <= fall_age_nxt;
    end
    default clocking cb @(posedge core_clk); endclocking
    chk_reset_state: assert property (
        reset |=> !tdo_oe && tap_in_reset && !mem_out_float)
        else $error("port not idle after reset");
    chk_tdo_on_fall: assert property (
        disable iff (reset) $changed(tdo_out) |-> fall_age_r >= 4'h3 && fall_age_r <= 4'h6)
        else $error("tdo moved outside a low phase");
    chk_oe_on_fall: assert property (
        disable iff (reset) $changed(tdo_oe) |-> fall_age_r >= 4'h3 && fall_age_r <= 4'h6)
        else $error("tdo enable moved outside a low phase");
    chk_tck_idle: assert property (
        disable iff (reset) !tck_pin [*8] |->
        $stable(tdo_oe) && $stable(tap_in_reset) && $stable(mem_out_float))
        else $error("port moved without test clock");
    chk_five_high: assert property (
        disable iff (reset) $rose(high_cnt_r == 3'h5) |-> ##[0:10] tap_in_reset)
        else $error("five high rises did not reset");
    chk_reset_loads_id: assert property (
        disable iff (reset) $rose(tap_in_reset) |-> ##[0:2] !mem_out_float)
        else $error("reset left a floating instruction");
    chk_oe_off_reset: assert property (
        disable iff (reset) tap_in_reset [*8] |-> !tdo_oe)
        else $error("tdo driven in reset state");
    chk_float_on_update: assert property (
        disable iff (reset) $changed(mem_out_float) |-> rise_age_r >= 4'h3 && rise_age_r <= 4'h6)
        else $error("instruction changed off a rise");
endmodule // sram_boundary_scan_tap_asserts
bind sram_boundary_scan_tap sram_boundary_scan_tap_asserts sram_boundary_scan_tap_asserts_inst (
    .core_clk(core_clk), .reset(reset), .tck_pin(tck_pin), .tms_pin(tms_pin),
    .tms_pin_connected(tms_pin_connected), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .mem_out_float(mem_out_float), .tap_in_reset(tap_in_reset));

/* File: tb/test_sram_boundary_scan_tap.sv */
// self-checking bench for the sram scan port
`timescale 1ns/10ps
module test_sram_boundary_scan_tap;
    localparam logic [31:0] ID = 32'h5a3c_0f01; // arbitrary value
    localparam logic [70:0] PINS = 71'h2a_0f0f_3c3c_a5a5_9669;
    localparam logic [7:0] PAT = 8'hc5;
    typedef struct packed {
        logic [2:0] code;
        logic [6:0] len;
        logic [1:0] kind;
        logic flt;
    } row_t;
    // instruction, chain length, captured value kind, memory outputs float
    row_t rows [8] = '{'{3'h0, 7'd71, 2'd2, 1'b1}, '{3'h1, 7'd32, 2'd1, 1'b0},
        '{3'h2, 7'd71, 2'd2, 1'b1}, '{3'h3, 7'd1, 2'd0, 1'b0}, '{3'h4, 7'd71, 2'd2, 1'b0},
        '{3'h5, 7'd1, 2'd0, 1'b0}, '{3'h6, 7'd1, 2'd0, 1'b0}, '{3'h7, 7'd1, 2'd0, 1'b0}};
    logic core_clk, reset, tck_pin, tms_pin, tms_pin_connected, tdi_pin, tdi_pin_connected;
    logic [70:0] pin_states;
    logic tdo_out, tdo_oe, mem_out_float, tap_in_reset, b;
    logic [127:0] d;
    int n_mismatch = 0;
    int n_checks = 0;
    sram_boundary_scan_tap #(.ID_CODE(ID), .BSR_LEN(71)) sram_boundary_scan_tap_inst (
        .core_clk(core_clk), .reset(reset), .tck_pin(tck_pin), .tms_pin(tms_pin),
        .tms_pin_connected(tms_pin_connected), .tdi_pin(tdi_pin),
        .tdi_pin_connected(tdi_pin_connected), .pin_states(pin_states), .tdo_out(tdo_out),
        .tdo_oe(tdo_oe), .mem_out_float(mem_out_float), .tap_in_reset(tap_in_reset));
    scan_tap_host scan_tap_host_inst (.tck_pin(tck_pin), .tms_pin(tms_pin),
        .tdi_pin(tdi_pin), .tdo_out(tdo_out), .tdo_oe(tdo_oe));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic st(input logic tms);
        scan_tap_host_inst.step(tms, 1'b1, b);
    endtask
    // captured value in the low bits, then the shifted-in pattern
    function automatic logic [127:0] expv(input logic [1:0] kind, input int len);
        logic [127:0] cap;
        cap = (kind == 2'd0) ? 128'h0 : (kind == 2'd1) ? 128'(ID) : 128'(PINS);
        return cap | (128'(PAT) << len);
    endfunction
    initial begin
        reset = 1'b1;
        tms_pin_connected = 1'b1;
        tdi_pin_connected = 1'b1;
        pin_states = PINS;
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        #200;
        check({tdo_oe, tap_in_reset, mem_out_float}, 3'b010);
        st(1'b0);
        scan_tap_host_inst.scan(1'b0, 40, 128'(PAT), d);
        check(d, expv(2'd1, 32));
        foreach (rows[k]) begin
            scan_tap_host_inst.scan(1'b1, 3, 128'(rows[k].code), d);
            check(d[1:0], 2'b01);
            #200;
            check(mem_out_float, rows[k].flt);
            scan_tap_host_inst.scan(1'b0, rows[k].len + 8, 128'(PAT), d);
            check(d, expv(rows[k].kind, rows[k].len));
        end
        tdi_pin_connected = 1'b0;
        repeat (2) begin
            scan_tap_host_inst.scan(1'b0, 4, 128'h0, d);
            check(d, 128'he);
        end
        tdi_pin_connected = 1'b1;
        st(1'b1);
        st(1'b0);
        st(1'b0);
        tms_pin_connected = 1'b0;
        repeat (4) st(1'b0);
        #200;
        check(tap_in_reset, 1'b0);
        st(1'b0);
        #200;
        check(tap_in_reset, 1'b1);
        tms_pin_connected = 1'b1;
        st(1'b0);
        scan_tap_host_inst.scan(1'b1, 3, 128'h0, d);
        repeat (3) st(1'b1);
        #200;
        check({tap_in_reset, mem_out_float}, 2'b10);
        st(1'b0);
        scan_tap_host_inst.scan(1'b1, 3, 128'h0, d);
        #200;
        reset = 1'b1;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        #200;
        check({tdo_oe, tap_in_reset, mem_out_float}, 3'b010);
        st(1'b0);
        scan_tap_host_inst.scan(1'b0, 40, 128'(PAT), d);
        check(d, expv(2'd1, 32));
        final_report;
    end
    // whole sequence takes roughly 185 us
    initial begin
        #3_000_000;
        n_mismatch++;
        final_report;
    end
endmodule // test_sram_boundary_scan_tap
